// File: core/fwg_defs.svh
// Register addresses, field positions, key codes and reset values of the flash guard block
`ifndef FWG_DEFS_SVH
`define FWG_DEFS_SVH

// ****************************************
// Register addresses
// ****************************************
`define FWG_ADDR_STORE_CTL 8'h8f
`define FWG_ADDR_FLASH_KEY 8'hb7
`define FWG_ADDR_SBYTE_ADDR 8'hb6
`define FWG_ADDR_SBYTE_DATA 8'hd1
`define FWG_ADDR_STORAGE_CTL 8'hc5
`define FWG_ADDR_STORAGE_KEY 8'hc6

// ****************************************
// Field positions
// ****************************************
`define FWG_BIT_WRITE_EN 0
`define FWG_BIT_ERASE_EN 1
`define FWG_BIT_LOGIC_EN 7
`define FWG_BIT_UPLOAD 2
`define FWG_BIT_DOWNLOAD 1
`define FWG_BIT_ADDRESS_AUTO_INCREMENT 0

// ****************************************
// Key codes and reset values
// ****************************************
`define FWG_FLASH_KEY1 8'ha5
`define FWG_FLASH_KEY2 8'hf1
`define FWG_STORE_KEY1 8'h55
`define FWG_STORE_KEY2 8'haa
`define FWG_STORAGE_CTL_RST 8'h01
`define FWG_SBYTE_DATA_RST 8'hff

`endif

// File: core/fwg_pkg.sv
// Types shared by the flash guard block
package fwg_pkg;

  // Two-bit protection states, encoded as they read back
  typedef enum logic [1:0] {
    FWG_LOCKED,
    FWG_FIRST_KEY,
    FWG_UNLOCKED,
    FWG_DISABLED
  } fwg_lock_t;

endpackage

// File: core/fwg_key_seq.sv
// Two-byte key sequence lock machine, used for flash and for emulated storage
`timescale 1ns/1ps
`include "fwg_defs.svh"

module fwg_key_seq #(
  parameter logic [7:0] KEY1 = 8'h00,
  parameter logic [7:0] KEY2 = 8'h00
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Events
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  input wire logic op_done,
  input wire logic op_attempt,
  // State
  output fwg_pkg::fwg_lock_t state
);

  fwg_pkg::fwg_lock_t state_reg;
  fwg_pkg::fwg_lock_t state_next;

  assign state = state_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fwg_pkg::FWG_LOCKED: begin
        if (key_wr) begin
          state_next = (key_data == KEY1) ? fwg_pkg::FWG_FIRST_KEY : fwg_pkg::FWG_DISABLED;
        end else if (op_attempt) begin
          state_next = fwg_pkg::FWG_DISABLED;
        end
      end
      fwg_pkg::FWG_FIRST_KEY: begin
        if (key_wr) begin
          state_next = (key_data == KEY2) ? fwg_pkg::FWG_UNLOCKED : fwg_pkg::FWG_DISABLED;
        end else if (op_attempt) begin
          state_next = fwg_pkg::FWG_DISABLED;
        end
      end
      fwg_pkg::FWG_UNLOCKED: begin
        // Any further key write while open is a wrong sequence
        if (key_wr) begin
          state_next = fwg_pkg::FWG_DISABLED;
        end else if (op_done) begin
          state_next = fwg_pkg::FWG_LOCKED;
        end
      end
      default: begin
        state_next = fwg_pkg::FWG_DISABLED;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= fwg_pkg::FWG_LOCKED;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

// File: core/fwg_guard.sv
// Flash write guard and 32-byte emulated storage, on the special register bus
`timescale 1ns/1ps
`include "fwg_defs.svh"

// Operation
// - Store control upper six bits read zero
// - Write enable sends external writes to flash
// - Erase plus write enable erases page
// - Flash key A5 then F1 enables
// - Flash permission clears after one operation
// - Bad key or blocked attempt locks permanently
// - Non-A5 first key locks flash
// - Flash key reads lock state low bits
// - Thirty-two byte image RAM mirrors storage
// - Storage access only when logic enabled
// - Data write stores at byte address
// - Data read returns RAM at address
// - Auto-increment after each data access
// - Address wraps from top to zero
// - Upload copies storage into image RAM
// - Download copies image RAM into storage
// - Download refused without storage key
// - Storage key is 55 then AA
// - Storage relocks after one download
// - Bad key or refused download locks
// - Storage key reads protect state harmlessly
module fwg_guard #(
  parameter int STORE_BYTES = 32,
  parameter int ADDR_W = 5
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Special register bus
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // External-move write from the core
  input wire logic xmove_wr,
  input wire logic [15:0] xmove_addr,
  input wire logic [7:0] xmove_wdata,
  // Flash programming engine
  output logic flash_prog,
  output logic flash_erase,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  input wire logic flash_done,
  // Ordinary external data memory
  output logic xram_wr,
  output logic [15:0] xram_addr,
  output logic [7:0] xram_wdata,
  // Non-volatile storage backing array
  output logic nv_wr,
  output logic [ADDR_W-1:0] nv_addr,
  output logic [7:0] nv_wdata,
  input wire logic [7:0] nv_rdata,
  output logic storage_busy
);

  // ****************************************
  // Register decode
  // ****************************************
  logic wr_store_ctl;
  logic wr_flash_key;
  logic wr_sbyte_addr;
  logic wr_sbyte_data;
  logic wr_storage_ctl;
  logic wr_storage_key;
  logic rd_sbyte_data;

  always_comb begin
    wr_store_ctl = 1'b0;
    wr_flash_key = 1'b0;
    wr_sbyte_addr = 1'b0;
    wr_sbyte_data = 1'b0;
    wr_storage_ctl = 1'b0;
    wr_storage_key = 1'b0;
    if (sfr_addr == `FWG_ADDR_STORE_CTL) begin
      wr_store_ctl = sfr_wr;
    end else if (sfr_addr == `FWG_ADDR_FLASH_KEY) begin
      wr_flash_key = sfr_wr;
    end else if (sfr_addr == `FWG_ADDR_SBYTE_ADDR) begin
      wr_sbyte_addr = sfr_wr;
    end else if (sfr_addr == `FWG_ADDR_SBYTE_DATA) begin
      wr_sbyte_data = sfr_wr;
    end else if (sfr_addr == `FWG_ADDR_STORAGE_CTL) begin
      wr_storage_ctl = sfr_wr;
    end else if (sfr_addr == `FWG_ADDR_STORAGE_KEY) begin
      wr_storage_key = sfr_wr;
    end
  end

  // Only data reads have a side effect, so the read strobe is decoded there alone
  assign rd_sbyte_data = sfr_rd && (sfr_addr == `FWG_ADDR_SBYTE_DATA);

  // ****************************************
  // Program store control
  // ****************************************
  logic write_en_reg;
  logic erase_en_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      write_en_reg <= 1'b0;
      erase_en_reg <= 1'b0;
    end else if (wr_store_ctl) begin
      write_en_reg <= sfr_wdata[`FWG_BIT_WRITE_EN];
      erase_en_reg <= sfr_wdata[`FWG_BIT_ERASE_EN];
    end
  end

  // ****************************************
  // Flash key lock
  // ****************************************
  fwg_pkg::fwg_lock_t flash_state;
  logic flash_req;
  logic flash_ok;
  logic flash_busy_reg;

  assign flash_req = xmove_wr && write_en_reg;
  assign flash_ok = (flash_state == fwg_pkg::FWG_UNLOCKED);

  // The key stays open until the engine reports done, however slow it is
  // Key pair opens flash
  fwg_key_seq #(
    .KEY1(`FWG_FLASH_KEY1),
    .KEY2(`FWG_FLASH_KEY2)
  ) u_flash_key (
    .core_clk(core_clk),
    .rst(rst),
    .key_wr(wr_flash_key),
    .key_data(sfr_wdata),
    .op_done(flash_done && flash_busy_reg),
    .op_attempt(flash_req && !flash_ok),
    .state(flash_state)
  );

  // ****************************************
  // External-move steering
  // ****************************************
  // A move arriving while an operation is pending is dropped; the core waits for done
  // Redirect to flash
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flash_prog <= 1'b0;
      flash_erase <= 1'b0;
      flash_addr <= 16'h0000;
      flash_wdata <= 8'h00;
      flash_busy_reg <= 1'b0;
    end else begin
      flash_prog <= flash_req && flash_ok && !flash_busy_reg && !erase_en_reg;
      flash_erase <= flash_req && flash_ok && !flash_busy_reg && erase_en_reg;
      if (flash_req && flash_ok && !flash_busy_reg) begin
        flash_addr <= xmove_addr;
        flash_wdata <= xmove_wdata;
        flash_busy_reg <= 1'b1;
      end else if (flash_done) begin
        flash_busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xram_wr <= 1'b0;
      xram_addr <= 16'h0000;
      xram_wdata <= 8'h00;
    end else begin
      xram_wr <= xmove_wr && !write_en_reg;
      xram_addr <= xmove_addr;
      xram_wdata <= xmove_wdata;
    end
  end

  // ****************************************
  // Storage control and image RAM
  // ****************************************
  logic logic_en_reg;
  logic address_auto_increment_reg;
  logic [ADDR_W-1:0] byte_addr_reg;
  logic [7:0] data_out_reg;
  logic [7:0] image_ram [STORE_BYTES];
  fwg_pkg::fwg_lock_t store_state;
  logic upload_req;
  logic download_req;
  logic upload_reg;
  logic download_reg;
  logic copy_phase_reg;
  logic [ADDR_W-1:0] copy_idx_reg;
  logic copy_last;

  // Reset image of the storage control byte; its enable and increment bits are kept
  localparam logic [7:0] STORAGE_CTL_RST = `FWG_STORAGE_CTL_RST;

  assign upload_req = wr_storage_ctl && sfr_wdata[`FWG_BIT_LOGIC_EN]
    && sfr_wdata[`FWG_BIT_UPLOAD] && !storage_busy;
  assign download_req = wr_storage_ctl && sfr_wdata[`FWG_BIT_LOGIC_EN]
    && sfr_wdata[`FWG_BIT_DOWNLOAD] && !sfr_wdata[`FWG_BIT_UPLOAD] && !storage_busy;
  assign copy_last = (copy_idx_reg == ADDR_W'(STORE_BYTES - 1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      logic_en_reg <= STORAGE_CTL_RST[`FWG_BIT_LOGIC_EN];
      address_auto_increment_reg <= STORAGE_CTL_RST[`FWG_BIT_ADDRESS_AUTO_INCREMENT];
    end else if (wr_storage_ctl) begin
      logic_en_reg <= sfr_wdata[`FWG_BIT_LOGIC_EN];
      address_auto_increment_reg <= sfr_wdata[`FWG_BIT_ADDRESS_AUTO_INCREMENT];
    end
  end

  fwg_key_seq #(
    .KEY1(`FWG_STORE_KEY1),
    .KEY2(`FWG_STORE_KEY2)
  ) u_store_key (
    .core_clk(core_clk),
    .rst(rst),
    .key_wr(wr_storage_key),
    .key_data(sfr_wdata),
    .op_done(download_reg && copy_last && copy_phase_reg),
    .op_attempt(download_req && store_state != fwg_pkg::FWG_UNLOCKED),
    .state(store_state)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      byte_addr_reg <= '0;
    end else if (wr_sbyte_addr) begin
      byte_addr_reg <= sfr_wdata[ADDR_W-1:0];
    end else if (logic_en_reg && address_auto_increment_reg && (wr_sbyte_data || rd_sbyte_data)) begin
      byte_addr_reg <= (byte_addr_reg == ADDR_W'(STORE_BYTES - 1)) ? '0 : byte_addr_reg + 1'b1;
    end
  end

  // Copy sequencer: one byte per two cycles so the array read settles
  // Upload or download all bytes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      upload_reg <= 1'b0;
      download_reg <= 1'b0;
      copy_phase_reg <= 1'b0;
      copy_idx_reg <= '0;
    end else if (upload_reg || download_reg) begin
      copy_phase_reg <= !copy_phase_reg;
      if (copy_phase_reg) begin
        copy_idx_reg <= copy_idx_reg + 1'b1;
        if (copy_last) begin
          upload_reg <= 1'b0;
          download_reg <= 1'b0;
        end
      end
    end else if (upload_req) begin
      upload_reg <= 1'b1;
      copy_idx_reg <= '0;
      copy_phase_reg <= 1'b0;
    end else if (download_req && store_state == fwg_pkg::FWG_UNLOCKED) begin
      download_reg <= 1'b1;
      copy_idx_reg <= '0;
      copy_phase_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nv_wr <= 1'b0;
      nv_addr <= '0;
      nv_wdata <= 8'h00;
      storage_busy <= 1'b0;
    end else begin
      nv_wr <= download_reg && !copy_phase_reg;
      nv_addr <= (upload_reg || download_reg) ? copy_idx_reg : '0;
      nv_wdata <= image_ram[copy_idx_reg];
      // Busy rises with the request so a second start in the next cycle is refused
      storage_busy <= (upload_reg || download_reg || upload_req || download_req)
        && !((upload_reg || download_reg) && copy_phase_reg && copy_last);
    end
  end

  // Copy traffic owns the array; register writes during a copy are lost, not queued
  // Image RAM
  always_ff @(posedge core_clk) begin
    if (upload_reg && copy_phase_reg) begin
      image_ram[copy_idx_reg] <= nv_rdata;
    end else if (wr_sbyte_data && logic_en_reg && !storage_busy) begin
      image_ram[byte_addr_reg] <= sfr_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      data_out_reg <= `FWG_SBYTE_DATA_RST;
    end else if (logic_en_reg) begin
      data_out_reg <= image_ram[byte_addr_reg];
    end
  end

  // ****************************************
  // Read-back mux
  // ****************************************
  // Registered: the value for an address shows one cycle after it is presented
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_addr == `FWG_ADDR_STORE_CTL) begin
      sfr_rdata <= {6'h00, erase_en_reg, write_en_reg};
    end else if (sfr_addr == `FWG_ADDR_FLASH_KEY) begin
      sfr_rdata <= {6'h00, flash_state};
    end else if (sfr_addr == `FWG_ADDR_SBYTE_ADDR) begin
      sfr_rdata <= 8'(byte_addr_reg);
    end else if (sfr_addr == `FWG_ADDR_SBYTE_DATA) begin
      sfr_rdata <= data_out_reg;
    end else if (sfr_addr == `FWG_ADDR_STORAGE_CTL) begin
      sfr_rdata <= {logic_en_reg, 4'h0, upload_reg, download_reg, address_auto_increment_reg};
    end else if (sfr_addr == `FWG_ADDR_STORAGE_KEY) begin
      // Protect state, read has no effect
      sfr_rdata <= {6'h00, store_state};
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

endmodule

// File: verif/fwg_guard_assertions.sv
// Port checks for the flash guard block
`timescale 1ns/1ps
module fwg_guard_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register bus
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // External move, flash and storage
  input wire logic xmove_wr,
  input wire logic [15:0] xmove_addr,
  input wire logic [7:0] xmove_wdata,
  input wire logic flash_prog,
  input wire logic flash_erase,
  input wire logic [15:0] flash_addr,
  input wire logic [7:0] flash_wdata,
  input wire logic xram_wr,
  input wire logic [15:0] xram_addr,
  input wire logic [7:0] xram_wdata,
  input wire logic nv_wr,
  input wire logic storage_busy
);
  logic we_reg, ee_reg, k1_reg, arm_reg, dead_reg, s1_reg, sok_reg, busy_reg;
  wire fk = sfr_wr && sfr_addr == 8'hb7;
  wire sk = sfr_wr && sfr_addr == 8'hc6;
  wire op = flash_prog || flash_erase;
  wire k1 = fk && sfr_wdata == 8'ha5 && !k1_reg && !arm_reg;
  wire k2 = fk && sfr_wdata == 8'hf1 && k1_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      we_reg <= 1'h0;
      ee_reg <= 1'h0;
    end else if (sfr_wr && sfr_addr == 8'h8f) begin
      we_reg <= sfr_wdata[0];
      ee_reg <= sfr_wdata[1];
    end
  end

  // Shadow key machine; a dropped move during a pending op is not modelled
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      k1_reg <= 1'h0;
      arm_reg <= 1'h0;
      dead_reg <= 1'h0;
    end else begin
      if (fk) k1_reg <= k1;
      arm_reg <= k2 || (arm_reg && !op && !fk);
      if ((fk && !k1 && !k2) || (xmove_wr && we_reg && !arm_reg)) dead_reg <= 1'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 1'h0;
      sok_reg <= 1'h0;
      busy_reg <= 1'h0;
    end else begin
      busy_reg <= storage_busy;
      if (sk) s1_reg <= sfr_wdata == 8'h55 && !s1_reg;
      if (sk && s1_reg && sfr_wdata == 8'haa) sok_reg <= 1'h1;
      else if (sk || (busy_reg && !storage_busy)) sok_reg <= 1'h0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_xram_path: assert property (
    xmove_wr && !we_reg |=> xram_wr && xram_addr == $past(xmove_addr)
    && xram_wdata == $past(xmove_wdata)) else $error("external memory copy wrong");
  a_flash_steer: assert property (
    xmove_wr && we_reg |=> !xram_wr) else $error("move leaked to external memory");
  a_prog_cause: assert property (
    flash_prog |-> $past(xmove_wr && we_reg && !ee_reg) && flash_addr == $past(xmove_addr)
    && flash_wdata == $past(xmove_wdata)) else $error("program without its move");
  a_erase_cause: assert property (
    flash_erase |-> $past(xmove_wr && we_reg && ee_reg) && flash_addr == $past(xmove_addr))
    else $error("erase without its move");
  a_op_keyed: assert property (
    op |-> arm_reg && !dead_reg) else $error("flash op without valid key");
  a_op_pulse: assert property (
    op |=> !op [*2]) else $error("flash op repeated");
  a_ctl_upper: assert property (
    $past(sfr_addr) == 8'h8f |-> sfr_rdata[7:2] == 6'h00) else $error("upper bits not zero");
  a_busy_bound: assert property (
    $rose(storage_busy) |-> ##[1:80] !storage_busy) else $error("copy never ends");
  a_nv_keyed: assert property (
    nv_wr |-> sok_reg) else $error("storage written without key");

  c_prog: cover property (flash_prog);
  c_erase: cover property (flash_erase);
  c_copy: cover property (nv_wr);
endmodule

// File: verif/fwg_far_model.sv
// Flash engine and storage array standing behind the guard
`timescale 1ns/1ps
module fwg_far_model (
  // Clock and pace
  input wire logic core_clk,
  input wire logic slow,
  // Flash engine
  input wire logic flash_prog,
  input wire logic flash_erase,
  input wire logic [15:0] flash_addr,
  input wire logic [7:0] flash_wdata,
  output logic flash_done,
  // Storage array
  input wire logic nv_wr,
  input wire logic [4:0] nv_addr,
  input wire logic [7:0] nv_wdata,
  output logic [7:0] nv_rdata
);
  logic [7:0] fl_mem [64];
  logic [7:0] nv_mem [32];
  int cnt = 0;

  // Contents survive a device reset, so they are set once only
  initial begin
    flash_done = 1'h0;
    foreach (fl_mem[i]) fl_mem[i] = 8'hff;
    foreach (nv_mem[i]) nv_mem[i] = 8'h3c ^ 8'(i);
  end

  assign nv_rdata = nv_mem[nv_addr];

  always @(posedge core_clk) begin
    flash_done <= cnt == 1;
    if (cnt > 0) cnt <= cnt - 1;
    if (flash_prog || flash_erase) cnt <= slow ? 9 : 2;
    if (nv_wr) nv_mem[nv_addr] <= nv_wdata;
    if (flash_prog) fl_mem[flash_addr[5:0]] <= fl_mem[flash_addr[5:0]] & flash_wdata;
    if (flash_erase) for (int i = 0; i < 16; i++) fl_mem[{flash_addr[5:4], 4'(i)}] <= 8'hff;
  end
endmodule

// File: verif/testbench.sv
// Self-checking bench for the flash guard block
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic sfr_wr = 1'h0;
  logic sfr_rd = 1'h0;
  logic xmove_wr = 1'h0;
  logic slow = 1'h0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] xmove_wdata = 8'h00;
  logic [15:0] xmove_addr = 16'h0000;
  logic [7:0] sfr_rdata, flash_wdata, xram_wdata, nv_wdata, nv_rdata;
  logic [15:0] flash_addr, xram_addr;
  logic [4:0] nv_addr;
  logic flash_prog, flash_erase, flash_done, xram_wr, nv_wr, storage_busy;
  logic [7:0] fl_exp [64];
  logic [7:0] ram [32];
  int n_errors = 0;
  int tests_run = 0;
  integer seed = 32'h91d6;

  always #2 core_clk = ~core_clk;

  fwg_guard u_dut (.core_clk, .rst, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata,
    .xmove_wr, .xmove_addr, .xmove_wdata, .flash_prog, .flash_erase, .flash_addr,
    .flash_wdata, .flash_done, .xram_wr, .xram_addr, .xram_wdata, .nv_wr, .nv_addr,
    .nv_wdata, .nv_rdata, .storage_busy);
  fwg_far_model u_far (.core_clk, .slow, .flash_prog, .flash_erase, .flash_addr,
    .flash_wdata, .flash_done, .nv_wr, .nv_addr, .nv_wdata, .nv_rdata);

  function automatic logic [7:0] prog_exp(logic [7:0] old, logic [7:0] d);
    return old & d;
  endfunction

  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(logic [7:0] got, logic [7:0] exp, string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'h1;
    step(1);
    sfr_wr = 1'h0;
    // An idle edge keeps back-to-back writes from toggling the strobe in one step
    step(1);
  endtask

  // Extra idle cycle lets the data register follow an auto-increment
  task automatic rc(logic [7:0] a, logic [7:0] exp);
    sfr_addr = a;
    sfr_rd = 1'h1;
    step(1);
    sfr_rd = 1'h0;
    chk(sfr_rdata, exp, "register read");
    step(1);
  endtask

  task automatic xm(logic [15:0] a, logic [7:0] d);
    xmove_addr = a;
    xmove_wdata = d;
    xmove_wr = 1'h1;
    step(1);
    xmove_wr = 1'h0;
  endtask

  task automatic fop(logic [15:0] a, logic [7:0] d, logic [7:0] ctl);
    wr(8'hb7, 8'ha5);
    rc(8'hb7, 8'h01);
    wr(8'hb7, 8'hf1);
    rc(8'hb7, 8'h02);
    wr(8'h8f, ctl);
    xm(a, d);
    chk({6'h00, flash_erase, flash_prog}, {6'h00, ctl[1], !ctl[1]}, "flash strobe");
    chk(flash_addr[7:0], a[7:0], "flash addr");
    for (int i = 0; i < 20 && flash_done !== 1'h1; i++) step(1);
    chk({7'h00, flash_done}, 8'h01, "flash done late");
    step(1);
    rc(8'hb7, 8'h00);
  endtask

  task automatic wbusy();
    step(2);
    for (int i = 0; i < 100 && storage_busy !== 1'h0; i++) step(1);
    chk({7'h00, storage_busy}, 8'h00, "copy still busy");
  endtask

  task automatic reset_dut();
    rst = 1'h1;
    step(16);
    rst = 1'h0;
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    logic [15:0] a;
    logic [7:0] d;
    logic [15:0] rv [6] = '{16'h8f00, 16'hb700, 16'hb600, 16'hc501, 16'hc600, 16'hd1ff};
    foreach (fl_exp[i]) fl_exp[i] = 8'hff;
    reset_dut();
    foreach (rv[i]) rc(rv[i][15:8], rv[i][7:0]);
    wr(8'h8f, 8'hfc);
    rc(8'h8f, 8'h00);
    wr(8'h8f, 8'hff);
    rc(8'h8f, 8'h03);
    wr(8'h8f, 8'h00);
    $display("reset values done");
    repeat (4) begin
      a = 16'($random(seed));
      d = 8'($random(seed));
      xm(a, d);
      chk({7'h00, xram_wr}, 8'h01, "xram strobe");
      chk(xram_wdata, d, "xram data");
      chk(xram_addr[15:8], a[15:8], "xram addr");
      chk(xram_addr[7:0], a[7:0], "xram addr");
      chk(u_far.fl_mem[a[5:0]], 8'hff, "flash touched");
      step(1);
    end
    wr(8'h8f, 8'h01);
    xm(16'h0012, 8'h00);
    step(2);
    chk(u_far.fl_mem[18], 8'hff, "blocked write");
    rc(8'hb7, 8'h03);
    wr(8'hb7, 8'ha5);
    wr(8'hb7, 8'hf1);
    rc(8'hb7, 8'h03);
    reset_dut();
    $display("blocked flash done");
    for (int k = 0; k < 2; k++) begin
      slow = 1'(k);
      a = {10'h000, 6'($random(seed))};
      d = 8'($random(seed));
      fop(a, d, 8'h01);
      fl_exp[a[5:0]] = prog_exp(fl_exp[a[5:0]], d);
      chk(u_far.fl_mem[a[5:0]], fl_exp[a[5:0]], "program");
    end
    fop(a ^ 16'h0003, 8'h00, 8'h03);
    chk(u_far.fl_mem[a[5:0]], 8'hff, "erase");
    wr(8'h8f, 8'h01);
    xm(a, 8'h00);
    step(4);
    chk(u_far.fl_mem[a[5:0]], 8'hff, "relock");
    rc(8'hb7, 8'h03);
    reset_dut();
    wr(8'hb7, 8'h3c);
    rc(8'hb7, 8'h03);
    reset_dut();
    $display("keyed flash done");
    wr(8'hc5, 8'h81);
    wr(8'hb6, 8'h05);
    foreach (ram[i]) begin
      ram[5'(i + 5)] = 8'($random(seed));
      wr(8'hd1, ram[5'(i + 5)]);
    end
    wr(8'hb6, 8'h05);
    step(1);
    foreach (ram[i]) rc(8'hd1, ram[5'(i + 5)]);
    rc(8'hb6, 8'h05);
    wr(8'hc5, 8'h80);
    wr(8'hb6, 8'h0a);
    step(1);
    rc(8'hd1, ram[10]);
    wr(8'hc5, 8'h00);
    wr(8'hd1, ~ram[10]);
    wr(8'hc5, 8'h80);
    rc(8'hd1, ram[10]);
    $display("image access done");
    wr(8'hc6, 8'h55);
    rc(8'hc6, 8'h01);
    wr(8'hc6, 8'haa);
    rc(8'hc6, 8'h02);
    wr(8'hc5, 8'h82);
    wbusy();
    foreach (ram[i]) chk(u_far.nv_mem[i], ram[i], "download");
    rc(8'hc6, 8'h00);
    wr(8'hb6, 8'h00);
    wr(8'hd1, ~ram[0]);
    wr(8'hc5, 8'h82);
    wbusy();
    chk(u_far.nv_mem[0], ram[0], "refused");
    rc(8'hc6, 8'h03);
    wr(8'hc5, 8'h84);
    wbusy();
    wr(8'hb6, 8'h00);
    step(1);
    rc(8'hd1, ram[0]);
    $display("storage copy done");
    stop_test();
  end

  // The run needs about five hundred cycles; this leaves wide margin
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
endmodule

bind fwg_guard fwg_guard_assertions u_chk (.core_clk, .rst, .sfr_wr, .sfr_addr, .sfr_wdata,
  .sfr_rdata, .xmove_wr, .xmove_addr, .xmove_wdata, .flash_prog, .flash_erase, .flash_addr,
  .flash_wdata, .xram_wr, .xram_addr, .xram_wdata, .nv_wr, .storage_busy);
